/* File: logic/rss_regs.svh */
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ****************************************************************
// Register map (byte addresses on APB)
// ****************************************************************
`define ICS_ADDR        8'h00
`define SEQ_STAT_ADDR   8'h04

// Field positions of integrity_control_status
`define ICS_WDG_BIT     4
`define ICS_LOCK_BIT    3
`define ICS_LSDR_BIT    2
`define ICS_WARN_BIT    1
`define ICS_IE_BIT      0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS   100
`define DELAY_SHORT_CYC 256
`define DELAY_LONG_CYC  4096
`define FETCH_CYC       2
`define OUT_WIDTH_NS    20000
`define PLL_STARTUP_NS  100000
// Least times, rounded up to whole cycles
`define OUT_WIDTH_CYC   ((`OUT_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_STARTUP_CYC ((`PLL_STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Cycles masked after own release: the 3-cycle pin echo through latch and two sync stages, plus one spare
`define GUARD_CYC       3'h4

// ****************************************************************
// Vector
// ****************************************************************
`define RESET_VECTOR    16'hFFFE

`endif

/* File: logic/rss_pkg.sv */
package rss_pkg;

    // Sequencer phases
    typedef enum logic [2:0] {
        SEQ_RUN,
        SEQ_ACTIVE,
        SEQ_DELAY,
        SEQ_PLL,
        SEQ_FETCH
    } seq_state_t;

    // Cause of the reset in progress
    typedef enum logic [2:0] {
        SRC_POR,
        SRC_EXT,
        SRC_LSD,
        SRC_WDG,
        SRC_ILL
    } src_t;

    // Option byte straps
    typedef struct packed {
        logic       pll_en;
        logic       xtal;
        logic       lsd_en;
        logic [1:0] lsd_level;
    } opt_t;

    // Digital outputs of the analog supply block
    typedef struct packed {
        logic above_rise;
        logic above_fall;
        logic warn_below;
        logic pll_locked;
    } cmp_t;

endpackage : rss_pkg

/* File: logic/reset_sequence_supervisor.sv */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "rss_regs.svh"

module reset_sequence_supervisor
    import rss_pkg::*;
#(
    parameter int unsigned DELAY_SHORT = `DELAY_SHORT_CYC,
    parameter int unsigned DELAY_LONG  = `DELAY_LONG_CYC,
    parameter int unsigned OUT_WIDTH   = `OUT_WIDTH_CYC,
    parameter int unsigned PLL_STARTUP = `PLL_STARTUP_CYC
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Reset pin, three-signal form
    input  wire logic        RESET_PIN_I,
    output logic             RESET_PIN_O,
    output logic             RESET_PIN_OE_N,
    // Option straps and analog block
    input  wire opt_t        OPTIONS,
    input  wire cmp_t        SUPPLY_CMP,
    output logic      [1:0]  LSD_LEVEL,
    // Core side
    input  wire logic        WDG_UNDERFLOW,
    input  wire logic        ILLEGAL_OPCODE,
    input  wire logic        IRQ_ACK,
    output logic             CPU_RESET_N,
    output logic             VECTOR_FETCH,
    output logic      [15:0] VECTOR_ADDR,
    output logic             CLK_OUT_EN,
    output logic             IRQ
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        seq_state_t  seq;
        src_t        src;
        logic [15:0] cnt;
        logic [2:0]  guard;
        logic        drive;
        logic        ext_s1;
        logic        ext_s2;
        opt_t        opt_s1;
        opt_t        opt_s2;
        cmp_t        cmp_s1;
        cmp_t        cmp_s2;
        logic        lsd_low;
        logic        warn_d;
        logic        wdg_flag;
        logic        lsdr_flag;
        logic        irq_en;
        logic        irq_pend;
        logic [31:0] prdata;
        logic [15:0] vec;
    } st_t;

    // Power-on: sequence starts in the active phase with the pin pulled
    localparam st_t ST_RESET = '{
        seq: SEQ_ACTIVE, src: SRC_POR, cnt: 16'h0000, guard: `GUARD_CYC,
        drive: 1'b1, ext_s1: 1'b1, ext_s2: 1'b1, opt_s1: '0, opt_s2: '0,
        cmp_s1: '0, cmp_s2: '0, lsd_low: 1'b1, warn_d: 1'b0, wdg_flag: 1'b0,
        lsdr_flag: 1'b0, irq_en: 1'b0, irq_pend: 1'b0, prdata: 32'h0000_0000,
        vec: 16'h0000
    };

    st_t  s_r;
    st_t  s_nxt;
    logic ext_latch_r;
    logic ext_arst_n;

    // Combinational helpers, also watched by the assertions
    logic        ext_go;
    logic        lsd_go;
    logic        restart;
    logic        lsd_rst_evt;
    logic        warn_now;
    logic        rd_ics;
    logic        wr_ics;
    logic        in_lsd_reset;
    logic [15:0] dly_last;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Registers decoded on the APB
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `ICS_ADDR) || (a == `SEQ_STAT_ADDR);
    endfunction : addr_hit

    // Last count of the delay phase for the chosen clock source
    function automatic logic [15:0] delay_last(input logic xtal);
        delay_last = xtal ? 16'(DELAY_LONG - 1) : 16'(DELAY_SHORT - 1);
    endfunction : delay_last

    // Read value of a register
    function automatic logic [31:0] rd_value(input logic [7:0] a, input st_t s);
        rd_value = 32'h0000_0000;
        if (a == `ICS_ADDR) begin
            rd_value[`ICS_WDG_BIT]  = s.wdg_flag;
            rd_value[`ICS_LOCK_BIT] = s.cmp_s2.pll_locked;
            rd_value[`ICS_LSDR_BIT] = s.lsdr_flag;
            rd_value[`ICS_WARN_BIT] = s.warn_d;
            rd_value[`ICS_IE_BIT]   = s.irq_en;
        end else if (a == `SEQ_STAT_ADDR) begin
            rd_value[2:0] = s.seq;
            rd_value[6:4] = s.src;
        end
    endfunction : rd_value

    // ****************************************************************
    // Asynchronous pin capture
    // ****************************************************************
    // pin low sets latch with no clock
    // Set is asynchronous so a pulse in halt is not missed; release is clocked
    assign ext_arst_n = RESET_PIN_I & RST_N;

    always_ff @(posedge CLK_SYS or negedge ext_arst_n) begin
        if (!ext_arst_n) begin
            ext_latch_r <= 1'b1;
        end else begin
            ext_latch_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.ext_s1 = ext_latch_r;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.opt_s1 = OPTIONS;
        s_nxt.opt_s2 = s_r.opt_s1;
        s_nxt.cmp_s1 = SUPPLY_CMP;
        s_nxt.cmp_s2 = s_r.cmp_s1;

        if (!s_r.opt_s2.lsd_en) begin
            s_nxt.lsd_low = 1'b0;
        end else if (s_r.lsd_low) begin
            s_nxt.lsd_low = !s_r.cmp_s2.above_rise;
        end else begin
            s_nxt.lsd_low = !s_r.cmp_s2.above_fall;
        end

        // Own drive echoes back on the pin, so it is masked while it drains
        ext_go       = s_r.ext_s2 && (s_r.guard == 3'h0) && !s_r.drive
                       && (s_r.seq != SEQ_ACTIVE);
        in_lsd_reset = (s_r.seq == SEQ_ACTIVE) && (s_r.src == SRC_LSD);
        lsd_go       = s_r.lsd_low && !in_lsd_reset;
        restart      = lsd_go || WDG_UNDERFLOW || ILLEGAL_OPCODE || ext_go;
        dly_last     = delay_last(s_r.opt_s2.xtal);

        // sources start the sequence; supply has top priority
        if (lsd_go) begin
            s_nxt.seq = SEQ_ACTIVE;
            s_nxt.src = SRC_LSD;
            s_nxt.cnt = 16'h0000;
        end else if (WDG_UNDERFLOW) begin
            s_nxt.seq = SEQ_ACTIVE;
            s_nxt.src = SRC_WDG;
            s_nxt.cnt = 16'h0000;
        end else if (ILLEGAL_OPCODE) begin
            s_nxt.seq = SEQ_ACTIVE;
            s_nxt.src = SRC_ILL;
            s_nxt.cnt = 16'h0000;
        end else if (ext_go) begin
            s_nxt.seq = SEQ_ACTIVE;
            s_nxt.src = SRC_EXT;
            s_nxt.cnt = 16'h0000;
        end else begin
            unique case (s_r.seq)
                SEQ_RUN: begin
                    s_nxt.cnt = 16'h0000;
                end
                SEQ_ACTIVE: begin
                    if (s_r.cnt >= 16'(OUT_WIDTH - 1) && !s_r.lsd_low &&
                        !(s_r.src == SRC_EXT && s_r.ext_s2)) begin
                        s_nxt.seq = SEQ_DELAY;
                        s_nxt.cnt = 16'h0000;
                    end else if (s_r.cnt != 16'hFFFF) begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
                SEQ_DELAY: begin
                    if (s_r.cnt == dly_last) begin
                        s_nxt.seq = s_r.opt_s2.pll_en ? SEQ_PLL : SEQ_FETCH;
                        s_nxt.cnt = 16'h0000;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
                SEQ_PLL: begin
                    if (s_r.cnt == 16'(PLL_STARTUP - 1)) begin
                        s_nxt.seq = SEQ_FETCH;
                        s_nxt.cnt = 16'h0000;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
                SEQ_FETCH: begin
                    if (s_r.cnt == 16'(`FETCH_CYC - 1)) begin
                        s_nxt.seq = SEQ_RUN;
                        s_nxt.cnt = 16'h0000;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
                default: begin
                    s_nxt.seq = SEQ_ACTIVE;
                    s_nxt.cnt = 16'h0000;
                end
            endcase
        end

        s_nxt.vec = (s_nxt.seq == SEQ_FETCH) ? (`RESET_VECTOR | s_nxt.cnt) : 16'h0000;

        // pin low in delay and PLL wait
        // pin low during supply, watchdog and illegal resets
        // An external reset is left to the outside party until the delay phase
        s_nxt.drive = (s_nxt.seq == SEQ_DELAY) || (s_nxt.seq == SEQ_PLL) ||
                      ((s_nxt.seq == SEQ_ACTIVE) && (s_nxt.src != SRC_EXT));
        if (s_r.drive) begin
            s_nxt.guard = `GUARD_CYC;
        end else if (s_r.guard != 3'h0) begin
            s_nxt.guard = s_r.guard - 3'h1;
        end

        warn_now     = s_r.opt_s2.lsd_en && s_r.cmp_s2.warn_below;
        s_nxt.warn_d = warn_now;

        // APB accesses take effect in the access phase (no wait states)
        rd_ics = PSEL && PENABLE && !PWRITE && (PADDR == `ICS_ADDR);
        wr_ics = PSEL && PENABLE && PWRITE && (PADDR == `ICS_ADDR);
        if (PSEL && !PENABLE && !PWRITE) begin
            s_nxt.prdata = rd_value(PADDR, s_r);
        end

        // watchdog flag; supply reset clears, set beats write
        lsd_rst_evt = lsd_go;
        if (lsd_rst_evt) begin
            s_nxt.wdg_flag = 1'b0;
        end else if (WDG_UNDERFLOW) begin
            s_nxt.wdg_flag = 1'b1;
        end else if (wr_ics && !PWDATA[`ICS_WDG_BIT]) begin
            s_nxt.wdg_flag = 1'b0;
        end

        // supply reset flag, cleared on read, set wins
        s_nxt.lsdr_flag = lsd_rst_evt || (s_r.lsdr_flag && !rd_ics);

        // Enable is cleared whenever the core is held in reset
        if (s_nxt.seq != SEQ_RUN && s_nxt.seq != SEQ_FETCH) begin
            s_nxt.irq_en = 1'b0;
        end else if (wr_ics) begin
            s_nxt.irq_en = PWDATA[`ICS_IE_BIT];
        end

        // gated by enable; new edge beats acknowledge
        s_nxt.irq_pend = (warn_now && !s_r.warn_d && s_r.irq_en) ||
                         (s_r.irq_pend && !IRQ_ACK && s_r.irq_en);
    end

    // Register the state
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // open-drain: only ever drives low
    assign RESET_PIN_O    = 1'b0;
    assign RESET_PIN_OE_N = !s_r.drive;
    // threshold level to the analog block
    assign LSD_LEVEL      = s_r.opt_s2.lsd_level;
    assign PRDATA         = s_r.prdata;
    assign PREADY         = 1'b1;
    assign PSLVERR        = PSEL && PENABLE && !addr_hit(PADDR);
    assign CPU_RESET_N    = (s_r.seq == SEQ_RUN) || (s_r.seq == SEQ_FETCH);
    assign VECTOR_FETCH   = (s_r.seq == SEQ_FETCH);
    assign VECTOR_ADDR    = s_r.vec;
    assign CLK_OUT_EN     = (s_r.seq == SEQ_RUN) || (s_r.seq == SEQ_FETCH);
    assign IRQ            = s_r.irq_pend;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    AST_DELAY_PIN_LOW: assert property (
        s_r.seq == SEQ_DELAY |-> !RESET_PIN_OE_N && !RESET_PIN_O)
        else $error("Pin released during delay phase");

    AST_FETCH_VECTOR: assert property (
        VECTOR_FETCH |-> VECTOR_ADDR == (`RESET_VECTOR | s_r.cnt))
        else $error("Wrong vector address during fetch");

    AST_DELAY_LEN: assert property (
        (s_r.seq == SEQ_DELAY && s_r.cnt == dly_last && !restart)
        |=> s_r.seq != SEQ_DELAY && s_r.cnt == 16'h0000)
        else $error("Delay phase did not end on its last count");

    AST_FETCH_LEN: assert property (
        ($rose(VECTOR_FETCH) && !restart) ##1 !restart
        |-> VECTOR_FETCH ##1 s_r.seq == SEQ_RUN)
        else $error("Vector fetch not exactly two cycles");

    AST_PLL_WAIT: assert property (
        (s_r.seq == SEQ_DELAY && s_r.cnt == dly_last && s_r.opt_s2.pll_en && !restart)
        |=> s_r.seq == SEQ_PLL && !CLK_OUT_EN)
        else $error("PLL startup wait skipped");

    AST_WDG_RESET: assert property (
        WDG_UNDERFLOW && !lsd_go |=> s_r.seq == SEQ_ACTIVE && s_r.src == SRC_WDG
        && !RESET_PIN_OE_N)
        else $error("Watchdog underflow did not pull the pin");

    AST_ILLEGAL_RESET: assert property (
        ILLEGAL_OPCODE && !lsd_go && !WDG_UNDERFLOW |=> s_r.src == SRC_ILL)
        else $error("Illegal opcode did not start a reset");

    AST_EXT_CAPTURE: assert property (
        !RESET_PIN_I |-> ext_latch_r)
        else $error("External pin low not captured");

    AST_EXT_SYNC: assert property (
        $rose(ext_latch_r) |-> !s_r.ext_s2 ##1 !s_r.ext_s2 || s_r.ext_s1)
        else $error("Captured request bypassed synchroniser");

    AST_LSD_HOLD: assert property (
        s_r.lsd_low |=> s_r.seq == SEQ_ACTIVE && !RESET_PIN_OE_N)
        else $error("Low supply did not hold reset");

    AST_LSD_DISABLED: assert property (
        !s_r.opt_s2.lsd_en |=> !s_r.lsd_low && !s_r.warn_d)
        else $error("Detector or warning active while disabled");

    AST_WDG_FLAG: assert property (
        WDG_UNDERFLOW && !lsd_go |=> s_r.wdg_flag)
        else $error("Watchdog flag not set");

    AST_LSDR_READ: assert property (
        rd_ics && !lsd_go |=> !s_r.lsdr_flag)
        else $error("Supply reset flag not cleared by read");

    AST_IRQ_RAISE: assert property (
        $rose(s_r.warn_d) && $past(s_r.irq_en) |-> IRQ)
        else $error("Warning interrupt not raised");

    AST_IRQ_GATE: assert property (
        !s_r.irq_en |=> !IRQ)
        else $error("Interrupt raised while disabled");

    COV_WDG_SEQ: cover property (
        s_r.src == SRC_WDG && $rose(VECTOR_FETCH));
    COV_LONG_DELAY: cover property (
        s_r.seq == SEQ_DELAY && s_r.opt_s2.xtal && s_r.cnt == dly_last);
    COV_LSD_RESET: cover property (
        $rose(s_r.lsdr_flag));
    COV_EXT_RESET: cover property (
        s_r.src == SRC_EXT && s_r.seq == SEQ_DELAY);

endmodule : reset_sequence_supervisor

/* File: tb/rss_board_model.sv */
`timescale 1ns/1ps
// ****************************************
// Board side of the reset pin
// ****************************************
module rss_board_model (
    input  wire logic oe_n,
    input  wire logic drv,
    input  wire logic hold_low,
    output logic      pin
);
    // outside party may hold it low
    // Pull-up wins only when no party pulls, so the idle level is never a stale value
    assign pin = ((!oe_n && !drv) || hold_low) ? 1'b0 : 1'b1;
endmodule : rss_board_model

/* File: tb/reset_sequence_supervisor_tb_top.sv */
`timescale 1ns/1ps
// ****************************************
// Reset supervisor bench
// ****************************************
module reset_sequence_supervisor_tb_top;
    import rss_pkg::*;
    localparam int OW = 4;
    localparam int PS = 5;
    localparam int DL = 32;
    localparam int DS = 16;
    typedef struct {logic rd; logic err; logic [31:0] d; logic [31:0] m;} note_t;
    typedef struct {int tot; int mp;} seq_t;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pin, pin_o, oe_n, hold, wdg, ill, ack, cpu_rst_n, vf, clk_en, irq;
    logic [15:0] vaddr;
    logic [1:0]  lvl;
    opt_t        opt;
    cmp_t        sc;
    note_t       rq[$];
    seq_t        sq[$];
    int          n_fail, num_checks, rst_cnt, pull_cnt, fcnt, wf, cur_d;

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    reset_sequence_supervisor #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .OUT_WIDTH(OW),
        .PLL_STARTUP(PS)) dut_u (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RESET_PIN_I(pin), .RESET_PIN_O(pin_o), .RESET_PIN_OE_N(oe_n), .OPTIONS(opt),
        .SUPPLY_CMP(sc), .LSD_LEVEL(lvl), .WDG_UNDERFLOW(wdg), .ILLEGAL_OPCODE(ill),
        .IRQ_ACK(ack), .CPU_RESET_N(cpu_rst_n), .VECTOR_FETCH(vf), .VECTOR_ADDR(vaddr),
        .CLK_OUT_EN(clk_en), .IRQ(irq));
    rss_board_model board_u (.oe_n(oe_n), .drv(pin_o), .hold_low(hold), .pin(pin));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    function automatic logic sel(input int k);
        return k == 0 ? irq : cpu_rst_n;
    endfunction : sel

    // Bounded wait, sampled mid-cycle where outputs are settled
    task automatic waitfor(input int k, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (sel(k) !== v && n < lim);
        chk(32'(sel(k)), 32'(v));
        @(posedge clk_sys);
    endtask : waitfor

    task automatic stay(input int k, input logic v, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            chk(32'(sel(k)), 32'(v));
        end
        @(posedge clk_sys);
    endtask : stay

    // APB transfer; the result is noted for the scoreboard
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic er);
        rq.push_back(note_t'{!w, er, e, m});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the hang guard ends a wait for the slave's answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'($urandom), e, m, 1'b0);
    endtask : rd

    function automatic logic [31:0] ics(input int w, input int l, input int a, input int i);
        return {27'h0, w[0], 1'b1, l[0], a[0], i[0]};
    endfunction : ics

    // Scoreboard: takes the oldest note whenever a result appears
    always @(posedge clk_sys) begin
        note_t r;
        seq_t  s;
        if (psel && penable && pready) begin
            r = rq.pop_front();
            if (r.rd) chk(prdata & r.m, r.d & r.m);
            chk(32'(pslverr), 32'(r.err));
        end
        if (rst_n && !cpu_rst_n) begin
            rst_cnt++;
            pull_cnt += 32'(!oe_n);
        end
        if (vf) begin
            fcnt++;
            chk(32'(vaddr), fcnt == 1 ? 32'hFFFE : 32'hFFFF);
            chk(32'(clk_en), 32'h1);
            if (fcnt == 1) begin
                s = sq.pop_front();
                if (s.tot >= 0) chk(rst_cnt, s.tot);
                chk(32'(pull_cnt >= s.mp), 32'h1);
                rst_cnt = 0;
                pull_cnt = 0;
            end
        end else begin
            if (fcnt != 0) chk(fcnt, 2);
            fcnt = 0;
        end
    end

    // Hang guard, far beyond the expected run
    initial begin
        #(100 * 20000);
        n_fail++;
        give_verdict();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, wdg, ill, ack, hold} = '0;
        {n_fail, num_checks, rst_cnt, pull_cnt, fcnt, wf} = '0;
        rst_n = 1'b0;
        opt = opt_t'{1'b0, 1'b0, 1'b1, 2'h1};
        sc = cmp_t'{1'b1, 1'b1, 1'b0, 1'b1};
        void'($urandom(32'h7B03));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        sq.push_back(seq_t'{-1, DS});
        waitfor(1, 1'b1, 400);
        repeat (3) @(posedge clk_sys);
        rd(8'h00, ics(0, 0, 0, 0), 32'hFFFF_FFFB);
        rd(8'h00, ics(0, 0, 0, 0), '1);
        apb(1'b1, 8'h04, 32'($urandom), 0, 0, 0);
        // Supply detector powers up low, so power-on reset is logged as a supply reset
        rd(8'h04, 32'h20, '1);
        apb(1'b0, 8'h0C, 0, 0, '1, 1'b1);
        for (int k = 0; k < 4; k++) begin
            opt.xtal <= k[0];
            opt.pll_en <= k[1];
            cur_d = (k[0] ? DL : DS) + (k[1] ? PS : 0);
            repeat (3 + $urandom_range(0, 3)) @(posedge clk_sys);
            sq.push_back(seq_t'{OW + cur_d, OW + cur_d});
            if (k[0]) ill <= 1'b1;
            else wdg <= 1'b1;
            @(posedge clk_sys);
            {ill, wdg} <= 2'b00;
            if (!k[0]) wf = 1;
            waitfor(1, 1'b0, 4);
            waitfor(1, 1'b1, 400);
            repeat (3) @(posedge clk_sys);
            rd(8'h04, k[0] ? 32'h40 : 32'h30, '1);
            rd(8'h00, ics(wf, 0, 0, 0), '1);
            apb(1'b1, 8'h00, (32'($urandom) & 32'hFFFF_FFE0) | (k[1] ? 32'h11 : 32'h01), 0, 0, 0);
            if (!k[1]) wf = 0;
            rd(8'h00, ics(wf, 0, 0, 1), '1);
        end
        sc.warn_below <= 1'b1;
        waitfor(0, 1'b1, 5);
        rd(8'h00, ics(1, 0, 1, 1), '1);
        ack <= 1'b1;
        @(posedge clk_sys);
        ack <= 1'b0;
        stay(0, 1'b0, 3);
        sc.warn_below <= 1'b0;
        apb(1'b1, 8'h00, 32'h10, 0, 0, 0);
        repeat (3) @(posedge clk_sys);
        sc.warn_below <= 1'b1;
        stay(0, 1'b0, 6);
        opt.lsd_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        {sc.above_rise, sc.above_fall} <= 2'b00;
        stay(1, 1'b1, 8);
        rd(8'h00, ics(1, 0, 0, 0), '1);
        sc.warn_below <= 1'b0;
        opt.lsd_en <= 1'b1;
        sq.push_back(seq_t'{-1, cur_d + 8});
        waitfor(1, 1'b0, 5);
        stay(1, 1'b0, 8);
        sc.above_fall <= 1'b1;
        stay(1, 1'b0, 6);
        sc.above_rise <= 1'b1;
        waitfor(1, 1'b1, 400);
        repeat (3) @(posedge clk_sys);
        rd(8'h04, 32'h20, '1);
        // outside pulls the pin, levels 0 to 2
        for (int lv = 0; lv < 3; lv++) begin
            opt.lsd_level <= 2'(lv);
            sq.push_back(seq_t'{-1, cur_d});
            hold <= 1'b1;
            repeat (6 + $urandom_range(0, 4)) @(posedge clk_sys);
            hold <= 1'b0;
            waitfor(1, 1'b1, 400);
            repeat (3) @(posedge clk_sys);
            rd(8'h04, 32'h10, '1);
            chk(32'(lvl), 32'(lv));
        end
        rd(8'h00, ics(0, 1, 0, 0), '1);
        rd(8'h00, ics(0, 0, 0, 0), '1);
        give_verdict();
    end
endmodule : reset_sequence_supervisor_tb_top
